// *** verif/irq_unit_props.sv ***
// Checker for the interrupt controller ports.
// Assumes binding onto the controller top.
`timescale 1ns/1ps
`default_nettype none
module irq_unit_props (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Observed ports
    input wire logic       phaseTwo,
    input wire logic       stackFull,
    input wire logic       powerDown,
    input wire logic       loWrite,
    input wire logic       port_a_bit_five,
    input wire logic       port_a_dir_bit_five,
    input wire logic       timer0Overflow,
    input wire logic [7:0] loCtrl,
    input wire logic       irqAck,
    input wire logic [7:0] irqVector,
    input wire logic       wakeUp
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========
    // Entry step after a call
    sequence s_entry;
        ##1 (!irqAck && !loCtrl[0]);
    endsequence
    property p_entry; irqAck |-> s_entry; endproperty
    a_entry: assert property (p_entry) else $error("entry");
    property p_gate; irqAck |-> phaseTwo && !stackFull && loCtrl[0]; endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_prio; irqAck && loCtrl[4] && loCtrl[1] |-> irqVector == 8'h04; endproperty
    a_prio: assert property (p_prio) else $error("prio");
    property p_t0vec;
        irqAck && loCtrl[5] && loCtrl[2] && !(loCtrl[4] && loCtrl[1]) |-> irqVector == 8'h08;
    endproperty
    a_t0vec: assert property (p_t0vec) else $error("t0vec");
    property p_t0clr; irqAck && irqVector == 8'h08 && !timer0Overflow |=> !loCtrl[5]; endproperty
    a_t0clr: assert property (p_t0clr) else $error("t0clr");
    property p_keep; loCtrl[5] && !irqAck && !loWrite |=> loCtrl[5]; endproperty
    a_keep: assert property (p_keep) else $error("keep");
    property p_ext;
        $fell(port_a_bit_five) && port_a_dir_bit_five && loCtrl[1] |-> ##[1:5] loCtrl[4];
    endproperty
    a_ext: assert property (p_ext) else $error("ext");
    property p_prompt;
        phaseTwo && !stackFull && loCtrl[0] && loCtrl[5] && loCtrl[2] |-> irqAck;
    endproperty
    a_prompt: assert property (p_prompt) else $error("prompt");
    property p_wake; powerDown && timer0Overflow |-> wakeUp; endproperty
    a_wake: assert property (p_wake) else $error("wake");
endmodule
`default_nettype wire

// *** verif/mcu_vectored_interrupt_unit_bench.sv ***
// Bench for the interrupt controller with a sequencer model.
// Assumes inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module mcu_vectored_interrupt_unit_bench;
    logic       clk, rst, pop, loWrite, hiWrite, powerDown, pin, dir;
    logic       phaseTwo, stackFull, irqAck, wakeUp;
    logic [7:0] writeData, optionBits, loCtrl, hiCtrl, irqVector;
    logic [6:0] evs;
    logic [3:0] uart;
    int         badCount, testsRun;
    logic [7:0] vecs [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    seq_model #(.DEPTH(1)) seqModel (.clk, .rst, .irqAck, .pop, .phaseTwo, .stackFull);
    mcu_vectored_interrupt_unit DUT (.clk, .rst, .phaseTwo, .stackFull, .powerDown,
        .loWrite, .hiWrite, .writeData, .optionBits, .port_a_bit_five(pin),
        .port_a_dir_bit_five(dir), .timer0Overflow(evs[0]), .timer1Overflow(evs[1]),
        .timer2Overflow(evs[2]), .rcTimerBOverflow(evs[3]), .decoder_chan1_buffer(evs[4]),
        .rcTimerAOverflow(evs[5]), .decoder_chan0_buffer(evs[6]), .uartConditions(uart),
        .serial_setup_reg(4'h2), .loCtrl, .hiCtrl, .irqAck, .irqVector, .wakeUp);
    // ==========
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic hi, input logic [7:0] d);
        @(negedge clk);
        {hiWrite, loWrite, writeData} = {hi, !hi, d};
        @(negedge clk);
        {hiWrite, loWrite} = 2'h0;
    endtask
    task automatic ev(input int k);
        @(negedge clk);
        evs[k] = 1'b1;
        #1 chk({7'h0, wakeUp}, {7'h0, powerDown});
        @(negedge clk);
        evs = '0;
    endtask
    // Pin low long enough for the synchroniser
    task automatic fall();
        @(negedge clk);
        pin = 1'b0;
        repeat (5) @(negedge clk);
        pin = 1'b1;
        repeat (5) @(negedge clk);
    endtask
    task automatic waitAck(input logic [7:0] v, input logic p);
        for (int n = 0; n < 40 && irqAck !== 1'b1; n++) @(negedge clk);
        chk({7'h0, irqAck}, 8'h01);
        chk(irqVector, v);
        @(negedge clk);
        pop = p;
        @(negedge clk);
        pop = 1'b0;
    endtask
    task automatic wrapUp();
        if (badCount == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        badCount++;
        wrapUp();
    end
    // ==========
    // Tests
    initial begin
        {rst, pop, loWrite, hiWrite, powerDown, dir, pin} = 7'h41;
        {writeData, optionBits, evs, uart} = '0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        chk(loCtrl, 8'h00);
        chk(hiCtrl, 8'h88);
        chk(irqVector, 8'h00);
        wr(0, 8'h04);
        ev(0);
        repeat (10) @(negedge clk);
        chk(loCtrl, 8'h24);
        wr(0, 8'h25);
        waitAck(8'h08, 1);
        chk(loCtrl, 8'h04);
        wr(0, 8'h0E);
        wr(1, 8'h07);
        fall();
        chk(loCtrl, 8'h0E);
        dir = 1'b1;
        powerDown = 1'b1;
        fall();
        for (int k = 0; k < 7; k++) ev(k);
        powerDown = 1'b0;
        chk(loCtrl, 8'h7E);
        chk(hiCtrl, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            wr(0, loCtrl | 8'h01);
            waitAck(vecs[i], 1);
        end
        chk(loCtrl, 8'h0E);
        chk(hiCtrl, 8'h07);
        ev(0);
        wr(0, 8'h2F);
        waitAck(8'h08, 0);
        // Option off, then a gated-off condition, then a passing one
        for (int u = 0; u < 3; u++) begin
            optionBits = (u == 0) ? 8'h00 : 8'h80;
            @(negedge clk);
            uart = (u == 1) ? 4'h1 : 4'h2;
            @(negedge clk);
            uart = 4'h0;
            @(negedge clk);
            chk(hiCtrl, (u == 2) ? 8'h17 : 8'h07);
        end
        wr(0, 8'h0F);
        repeat (12) @(negedge clk);
        chk(hiCtrl, 8'h17);
        chk(loCtrl, 8'h0F);
        pop = 1'b1;
        @(negedge clk);
        pop = 1'b0;
        waitAck(8'h10, 1);
        chk(hiCtrl, 8'h07);
        wrapUp();
    end
endmodule
bind mcu_vectored_interrupt_unit irq_unit_props chk (.clk, .rst, .phaseTwo, .stackFull,
    .powerDown, .loWrite, .port_a_bit_five, .port_a_dir_bit_five, .timer0Overflow,
    .loCtrl, .irqAck, .irqVector, .wakeUp);
`default_nettype wire

// *** verif/seq_model.sv ***
// Sequencer and stack model: phase pulse and call depth.
// Assumes the bench pops one level after each served call.
`timescale 1ns/1ps
`default_nettype none
module seq_model #(
    parameter int DEPTH = 1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Calls and returns
    input  wire logic irqAck,
    input  wire logic pop,
    // To the controller
    output logic      phaseTwo,
    output logic      stackFull
);
    logic [1:0] phase_q;
    logic [3:0] depth_q;
    // ==========
    // Phase pulse every fourth cycle
    always_ff @(posedge clk) begin
        phase_q <= rst ? 2'h0 : phase_q + 2'h1;
    end
    assign phaseTwo = (phase_q == 2'h3);
    // ==========
    // one level per call
    always_ff @(posedge clk) begin
        depth_q <= rst ? 4'h0 : depth_q + {3'h0, irqAck} - {3'h0, pop};
    end
    // Small depth so that full is reached quickly
    assign stackFull = (depth_q >= 4'(DEPTH));
endmodule
`default_nettype wire

// *** verilog/irq_priority_pick.sv ***
// Fixed priority picker over the six maskable sources.
// Assumes bit 0 is the highest priority source.
`timescale 1ns/1ps
`default_nettype none
module irq_priority_pick #(
    parameter int N = 6
) (
    // Requests
    input  wire logic [N-1:0] pending,
    // Winner
    output logic              anyHit,
    output logic [2:0]        winner
);
    // ================================
    // Lowest index wins
    always_comb begin
        anyHit = 1'b0;
        winner = 3'(N);
        for (int i = N - 1; i >= 0; i--) begin
            if (pending[i]) begin
                anyHit = 1'b1;
                winner = 3'(i);
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/irq_unit_pkg.sv ***
// Types shared by the interrupt controller files.
// Assumes the register header is compiled alongside.
package irq_unit_pkg;
    typedef enum logic [2:0] {
        SRC_EXT,
        SRC_T0,
        SRC_T1,
        SRC_T2,
        SRC_RC,
        SRC_DEC,
        SRC_NONE
    } source_type;
endpackage

// *** verilog/irq_unit_regs.svh ***
// Bit positions, vector addresses and reset values of the interrupt controller.
// Assumes inclusion by bare name from design files.
`ifndef IRQ_UNIT_REGS_SVH
`define IRQ_UNIT_REGS_SVH

// ================================
// Low control byte fields
`define LO_GLOBAL_EN_BIT   0
`define LO_EXT_EN_BIT      1
`define LO_T0_EN_BIT       2
`define LO_T1_EN_BIT       3
`define LO_EXT_FLAG_BIT    4
`define LO_T0_FLAG_BIT     5
`define LO_T1_FLAG_BIT     6

// ================================
// High control byte fields
`define HI_T2_EN_BIT       0
`define HI_RC_EN_BIT       1
`define HI_DEC_EN_BIT      2
`define HI_CH0_FLAG_BIT    3
`define HI_T2_FLAG_BIT     4
`define HI_RC_FLAG_BIT     5
`define HI_DEC_FLAG_BIT    6
`define HI_CH1_FLAG_BIT    7

// ================================
// Vectors and reset values
`define VEC_RESET          8'h00
`define VEC_EXT            8'h04
`define VEC_T0             8'h08
`define VEC_T1             8'h0C
`define VEC_T2             8'h10
`define VEC_RC             8'h14
`define VEC_DEC            8'h18
`define LO_RESET_VAL       8'h00
`define HI_RESET_VAL       8'h88
`define UART_OPT_BIT       7
`define SRC_COUNT          6

`endif

// *** verilog/mcu_vectored_interrupt_unit.sv ***
// Vectored interrupt controller: flags, enables, priority, vector call.
// Assumes a sequencer that takes irqAck with irqVector and pushes the PC.
// Function
// - Taking any interrupt clears global enable
// - Flags latch even with global enable clear
// - No acknowledge while return stack is full
// - Requests serviced at next phase edge
// - Fixed priority, external highest after reset
// - External flag on falling pin edge
// - Pin acts only if enabled and input
// - External service: vector 04H, clear flags
// - Timer enables at documented bit positions
// - Timer overflows set their flags
// - Timer vectors 08H, 0CH, 10H when enabled
// - Timer entry clears its flag, global enable
// - UART option shares timer two resources
// - UART conditions gated by setup bits
// - Converter flag set by timer overflow
// - Converter service vector 14H, clears flags
// - Decoder channel flags and summary flag
// - Decoder service vector 18H, clears flags
// - Flags stay set until served/cleared
// - Any source event wakes from power down, the pin only if enabled and input
// - Acknowledge pushes PC, loads vector
// - Global enable clear masks all sources
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_regs.svh"
module mcu_vectored_interrupt_unit #(
    parameter int UART_SRC = 4
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Sequencer timing and stack
    input  wire logic                phaseTwo,
    input  wire logic                stackFull,
    input  wire logic                powerDown,
    // Software write of control bytes
    input  wire logic                loWrite,
    input  wire logic                hiWrite,
    input  wire logic [7:0]          writeData,
    // Configuration option bits
    input  wire logic [7:0]          optionBits,
    // Port pin shared with external request
    input  wire logic                port_a_bit_five,
    input  wire logic                port_a_dir_bit_five,
    // Peripheral events, one-cycle pulses, and the UART setup mask
    input  wire logic                timer0Overflow,
    input  wire logic                timer1Overflow,
    input  wire logic                timer2Overflow,
    input  wire logic [UART_SRC-1:0] uartConditions,
    input  wire logic [UART_SRC-1:0] serial_setup_reg,
    input  wire logic                rcTimerAOverflow,
    input  wire logic                rcTimerBOverflow,
    input  wire logic                decoder_chan0_buffer,
    input  wire logic                decoder_chan1_buffer,
    // Control byte readback
    output logic [7:0]               loCtrl,
    output logic [7:0]               hiCtrl,
    // Sequencer call
    output logic                     irqAck,
    output logic [7:0]               irqVector,
    output logic                     wakeUp
);
    // ================================
    // State
    localparam logic [7:0] LO_RESET = `LO_RESET_VAL;
    localparam logic [7:0] HI_RESET = `HI_RESET_VAL;
    logic       globalEn_q;
    logic       extEn_q;
    logic       t0En_q;
    logic       t1En_q;
    logic       t2En_q;
    logic       rcEn_q;
    logic       decEn_q;
    logic       extFlag_q;
    logic       t0Flag_q;
    logic       t1Flag_q;
    logic       t2Flag_q;
    logic       rcFlag_q;
    logic       decFlag_q;
    logic       ch0Flag_q;
    logic       ch1Flag_q;
    logic [7:0] irqVector_q;
    logic       pinSync1_q;
    logic       pinSync2_q;
    logic       pinPrev_q;
    logic [5:0] pending;
    logic       anyHit;
    logic [2:0] winner;
    logic       takeIrq;
    logic       extFall;
    logic       uartReq;
    logic       t2Event;
    logic       rcEvent;
    logic [5:0] served;
    irq_unit_pkg::source_type winSrc;

    // ================================
    // Pin synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            pinSync1_q <= 1'b1;
            pinSync2_q <= 1'b1;
            pinPrev_q  <= 1'b1;
        end else begin
            pinSync1_q <= port_a_bit_five;
            pinSync2_q <= pinSync1_q;
            pinPrev_q  <= pinSync2_q;
        end
    end

    // Pin used only when enabled and input
    assign extFall = pinPrev_q & ~pinSync2_q & port_a_dir_bit_five
                     & extEn_q;

    // UART conditions gated per setup bit
    // UART shares timer two flag under option
    assign uartReq = optionBits[`UART_OPT_BIT] & |(uartConditions & serial_setup_reg);
    // Timer two overflow or shared UART
    assign t2Event = timer2Overflow | uartReq;
    assign rcEvent = rcTimerAOverflow | rcTimerBOverflow;

    // ================================
    // Arbitration
    // Enabled pending sources
    // Timer two enable also gates UART
    assign pending = {6{globalEn_q}} & {
        decFlag_q & decEn_q,
        rcFlag_q  & rcEn_q,
        t2Flag_q  & t2En_q,
        t1Flag_q  & t1En_q,
        t0Flag_q  & t0En_q,
        extFlag_q & extEn_q
    };

    irq_priority_pick #(
        .N (`SRC_COUNT)
    ) u_pick (
        .pending (pending),
        .anyHit  (anyHit),
        .winner  (winner)
    );

    assign winSrc = irq_unit_pkg::source_type'(winner);

    // One clear strobe per source, in enum order
    for (genvar g = 0; g < `SRC_COUNT; g++) begin : g_served
        assign served[g] = takeIrq & (winner == 3'(g));
    end

    // Taken only on the phase edge
    assign takeIrq = phaseTwo & anyHit & ~stackFull;
    assign irqAck  = takeIrq;

    // Vector per source, used for the vector output and its held register
    function automatic logic [7:0] vectorOf(input irq_unit_pkg::source_type s);
        logic [7:0] v;
        v = `VEC_RESET;
        unique case (s)
            irq_unit_pkg::SRC_EXT:  v = `VEC_EXT;
            irq_unit_pkg::SRC_T0:   v = `VEC_T0;
            irq_unit_pkg::SRC_T1:   v = `VEC_T1;
            irq_unit_pkg::SRC_T2:   v = `VEC_T2;
            irq_unit_pkg::SRC_RC:   v = `VEC_RC;
            irq_unit_pkg::SRC_DEC:  v = `VEC_DEC;
            irq_unit_pkg::SRC_NONE: v = `VEC_RESET;
            default:                v = `VEC_RESET;
        endcase
        return v;
    endfunction

    // Vector held for the sequencer to load
    always_ff @(posedge clk) begin
        if (rst) begin
            irqVector_q <= `VEC_RESET;
        end else if (takeIrq) begin
            irqVector_q <= vectorOf(winSrc);
        end
    end

    // Vector is valid with the ack in the same cycle
    assign irqVector = takeIrq ? vectorOf(winSrc) : irqVector_q;

    // ================================
    // Global enable
    // Entry clears it, winning over a write
    // Software sets it again to allow nesting
    always_ff @(posedge clk) begin
        if (rst) begin
            globalEn_q <= LO_RESET[`LO_GLOBAL_EN_BIT];
        end else if (takeIrq) begin
            globalEn_q <= 1'b0;
        end else if (loWrite) begin
            globalEn_q <= writeData[`LO_GLOBAL_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            extEn_q <= LO_RESET[`LO_EXT_EN_BIT];
            t0En_q  <= LO_RESET[`LO_T0_EN_BIT];
            t1En_q  <= LO_RESET[`LO_T1_EN_BIT];
        end else if (loWrite) begin
            extEn_q <= writeData[`LO_EXT_EN_BIT];
            t0En_q  <= writeData[`LO_T0_EN_BIT];
            t1En_q  <= writeData[`LO_T1_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t2En_q  <= HI_RESET[`HI_T2_EN_BIT];
            rcEn_q  <= HI_RESET[`HI_RC_EN_BIT];
            decEn_q <= HI_RESET[`HI_DEC_EN_BIT];
        end else if (hiWrite) begin
            t2En_q  <= writeData[`HI_T2_EN_BIT];
            rcEn_q  <= writeData[`HI_RC_EN_BIT];
            decEn_q <= writeData[`HI_DEC_EN_BIT];
        end
    end

    // ================================
    // Request flags: event set beats entry clear beats write
    // Flags latch whatever the enables, except the external flag, which needs its enable
    // External flag, cleared on its entry
    always_ff @(posedge clk) begin
        if (rst) begin
            extFlag_q <= LO_RESET[`LO_EXT_FLAG_BIT];
        end else if (extFall) begin
            extFlag_q <= 1'b1;
        end else if (served[irq_unit_pkg::SRC_EXT]) begin
            extFlag_q <= 1'b0;
        end else if (loWrite) begin
            extFlag_q <= writeData[`LO_EXT_FLAG_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            t0Flag_q <= LO_RESET[`LO_T0_FLAG_BIT];
        end else if (timer0Overflow) begin
            t0Flag_q <= 1'b1;
        end else if (served[irq_unit_pkg::SRC_T0]) begin
            t0Flag_q <= 1'b0;
        end else if (loWrite) begin
            t0Flag_q <= writeData[`LO_T0_FLAG_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            t1Flag_q <= LO_RESET[`LO_T1_FLAG_BIT];
        end else if (timer1Overflow) begin
            t1Flag_q <= 1'b1;
        end else if (served[irq_unit_pkg::SRC_T1]) begin
            t1Flag_q <= 1'b0;
        end else if (loWrite) begin
            t1Flag_q <= writeData[`LO_T1_FLAG_BIT];
        end
    end
    // Timer 2 flag, shared with UART
    always_ff @(posedge clk) begin
        if (rst) begin
            t2Flag_q <= HI_RESET[`HI_T2_FLAG_BIT];
        end else if (t2Event) begin
            t2Flag_q <= 1'b1;
        end else if (served[irq_unit_pkg::SRC_T2]) begin
            t2Flag_q <= 1'b0;
        end else if (hiWrite) begin
            t2Flag_q <= writeData[`HI_T2_FLAG_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rcFlag_q <= HI_RESET[`HI_RC_FLAG_BIT];
        end else if (rcEvent) begin
            rcFlag_q <= 1'b1;
        end else if (served[irq_unit_pkg::SRC_RC]) begin
            rcFlag_q <= 1'b0;
        end else if (hiWrite) begin
            rcFlag_q <= writeData[`HI_RC_FLAG_BIT];
        end
    end
    // Decoder summary, set at once by either channel
    always_ff @(posedge clk) begin
        if (rst) begin
            decFlag_q <= HI_RESET[`HI_DEC_FLAG_BIT];
        end else if (decoder_chan0_buffer | decoder_chan1_buffer) begin
            decFlag_q <= 1'b1;
        end else if (served[irq_unit_pkg::SRC_DEC]) begin
            decFlag_q <= 1'b0;
        end else if (hiWrite) begin
            decFlag_q <= writeData[`HI_DEC_FLAG_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            ch0Flag_q <= HI_RESET[`HI_CH0_FLAG_BIT];
        end else if (decoder_chan0_buffer) begin
            ch0Flag_q <= 1'b1;
        end else if (served[irq_unit_pkg::SRC_DEC]) begin
            ch0Flag_q <= 1'b0;
        end else if (hiWrite) begin
            ch0Flag_q <= writeData[`HI_CH0_FLAG_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            ch1Flag_q <= HI_RESET[`HI_CH1_FLAG_BIT];
        end else if (decoder_chan1_buffer) begin
            ch1Flag_q <= 1'b1;
        end else if (served[irq_unit_pkg::SRC_DEC]) begin
            ch1Flag_q <= 1'b0;
        end else if (hiWrite) begin
            ch1Flag_q <= writeData[`HI_CH1_FLAG_BIT];
        end
    end

    // ================================
    // Readback, top bit of the low byte reads zero
    always_comb begin
        loCtrl                    = '0;
        loCtrl[`LO_GLOBAL_EN_BIT] = globalEn_q;
        loCtrl[`LO_EXT_EN_BIT]    = extEn_q;
        loCtrl[`LO_T0_EN_BIT]     = t0En_q;
        loCtrl[`LO_T1_EN_BIT]     = t1En_q;
        loCtrl[`LO_EXT_FLAG_BIT]  = extFlag_q;
        loCtrl[`LO_T0_FLAG_BIT]   = t0Flag_q;
        loCtrl[`LO_T1_FLAG_BIT]   = t1Flag_q;
        hiCtrl                    = '0;
        hiCtrl[`HI_T2_EN_BIT]     = t2En_q;
        hiCtrl[`HI_RC_EN_BIT]     = rcEn_q;
        hiCtrl[`HI_DEC_EN_BIT]    = decEn_q;
        hiCtrl[`HI_CH0_FLAG_BIT]  = ch0Flag_q;
        hiCtrl[`HI_T2_FLAG_BIT]   = t2Flag_q;
        hiCtrl[`HI_RC_FLAG_BIT]   = rcFlag_q;
        hiCtrl[`HI_DEC_FLAG_BIT]  = decFlag_q;
        hiCtrl[`HI_CH1_FLAG_BIT]  = ch1Flag_q;
    end

    // ================================
    // Wake-up
    // Any source event wakes the core, enables ignored except for the pin, which needs its enable and direction
    assign wakeUp = powerDown & (extFall | timer0Overflow | timer1Overflow | t2Event
                    | rcEvent | decoder_chan0_buffer | decoder_chan1_buffer);
endmodule
`default_nettype wire
